// >>> rxdd_pkg.sv
// Constants, field layout and state type of the receive descriptor decoder.
// Assumes a 32-bit APB register port and 32-bit host memory words.
package rxdd_pkg;

    // Register byte offsets
    localparam logic [7:0]  RXDD_CTRL_OFS   = 8'h00;
    localparam logic [7:0]  RXDD_BASE_OFS   = 8'h04;
    localparam logic [7:0]  RXDD_POLL_OFS   = 8'h08;
    localparam logic [7:0]  RXDD_STATUS_OFS = 8'h0C;
    localparam logic [7:0]  RXDD_CUR_OFS    = 8'h10;
    localparam logic [7:0]  RXDD_CTLW_OFS   = 8'h14;

    // Register reset values and field positions
    localparam logic [31:0] RXDD_ZERO_WORD  = 32'h0000_0000;
    localparam int          RXDD_RUN_BIT    = 0;
    localparam int          RXDD_SUSP_BIT   = 4;

    // Descriptor word fields
    localparam int          RXDD_OWN_BIT    = 31;
    localparam int          RXDD_WRAP_BIT   = 25;
    localparam int          RXDD_CHAIN_BIT  = 24;
    localparam int          RXDD_LEN2_LO    = 11;
    localparam int          RXDD_LEN1_LO    = 0;
    localparam int          RXDD_LEN_W      = 11;
    localparam int          RXDD_ADDR_W     = 32;
    localparam logic [10:0] RXDD_LEN_ZERO   = 11'h000;

    // Descriptor stepping
    localparam logic [31:0] RXDD_DESC_STRIDE = 32'h0000_0010;
    localparam logic [1:0]  RXDD_LAST_WORD   = 2'h3;

    // Buffer entry queue
    localparam int          RXDD_FIFO_DEPTH = 16;
    localparam int          RXDD_ENTRY_W    = RXDD_ADDR_W + RXDD_LEN_W + 1;

    // Fetch engine states
    typedef enum logic [2:0] {
        RXDD_IDLE,
        RXDD_FETCH,
        RXDD_PUSH1,
        RXDD_PUSH2,
        RXDD_NEXT,
        RXDD_SUSP
    } rxdd_state_t;

endpackage : rxdd_pkg

// >>> rxdd_fifo.sv
// Parameterised FIFO holding decoded buffer entries.
// Assumes one clock; output data and valid come straight from registers.
module rxdd_fifo #(
    parameter int WIDTH = 44,
    parameter int DEPTH = 16
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];   // Storage array
    logic [AW-1:0]    wr_ptr;        // Write index
    logic [AW-1:0]    rd_ptr;        // Read index
    logic [AW:0]      count;         // Words held in array
    logic             push;          // Accepted write
    logic             pop;           // Array word moved to output

    assign in_ready = (count != (AW+1)'(DEPTH));
    assign push     = in_valid && in_ready;
    assign pop      = (count != '0) && (!out_valid || out_ready);

    // Array write
    always_ff @(posedge clk)
    begin
        if (push)
            mem[wr_ptr] <= in_data;
    end

    // Pointers and fill count
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end
        else
        begin
            if (push)
                wr_ptr <= wr_ptr + 1'b1;
            if (pop)
                rd_ptr <= rd_ptr + 1'b1;
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    // Registered output stage
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            out_valid <= 1'b0;
            out_data  <= '0;
        end
        else if (pop)
        begin
            out_valid <= 1'b1;
            out_data  <= mem[rd_ptr];
        end
        else if (out_ready)
            out_valid <= 1'b0;
    end

endmodule : rxdd_fifo

// >>> rxdd_decoder.sv
// Receive descriptor decoder: fetches descriptors, decodes the control
// word, queues buffer entries and walks the descriptor list.
// Assumes an APB master, a memory read port on pclk and a buffer consumer.
module rxdd_decoder
    import rxdd_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             mem_rd_req,
    output logic      [31:0] mem_rd_addr,
    input  wire logic        mem_rd_ack,
    input  wire logic [31:0] mem_rd_data,
    output logic             buf_valid,
    input  wire logic        buf_ready,
    output logic      [31:0] buf_addr,
    output logic      [10:0] buf_len,
    output logic             buf_second
);

    rxdd_state_t              state;          // Fetch engine state
    logic                     run;            // Software enable
    logic [31:0]              list_base;      // Receive list base pointer
    logic                     poll_pend;      // Resume request pending
    logic [31:0]              cur_desc;       // Current descriptor address
    logic [1:0]               word_idx;       // Word being fetched
    logic                     ring_wrap_flag;     // Last descriptor in ring
    logic                     chain_pointer_flag; // Fourth word is next pointer
    logic [RXDD_LEN_W-1:0]    first_buf_len;  // First buffer length
    logic [RXDD_LEN_W-1:0]    second_buf_len; // Second buffer length
    logic [31:0]              rx_desc_word1;  // Last control word seen
    logic [31:0]              rx_desc_word2;  // First buffer pointer
    logic [31:0]              rx_desc_word3;  // Second pointer word
    logic                     apb_access;     // Access phase, not answered
    logic                     apb_wr;         // Write takes effect
    logic                     chained;        // Chain honoured
    logic                     buf2_used;      // Second buffer carries data
    logic                     push_valid;     // Entry offered to FIFO
    logic [RXDD_ENTRY_W-1:0]  push_data;      // Entry contents
    logic                     push_ready;     // FIFO has room
    logic [RXDD_ENTRY_W-1:0]  fifo_out;       // FIFO output word
    logic [31:0]              next_desc;      // Address of following descriptor
    logic [31:0]              status_word;    // Status read value
    logic                     mapped;         // Address decodes

    // APB handshake terms
    assign apb_access = psel && penable && !pready;
    assign apb_wr     = psel && penable && pready && pwrite;

    // Address decode
    always_comb
    begin
        case (paddr)
            RXDD_CTRL_OFS, RXDD_BASE_OFS, RXDD_POLL_OFS,
            RXDD_STATUS_OFS, RXDD_CUR_OFS, RXDD_CTLW_OFS:
                mapped = 1'b1;
            default:
                mapped = 1'b0;
        endcase
    end

    // Status word: state code and suspended flag
    always_comb
    begin
        status_word = RXDD_ZERO_WORD;
        status_word[2:0] = state;
        status_word[RXDD_SUSP_BIT] = (state == RXDD_SUSP);
    end

    // APB answer: one wait cycle, then ready with data
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= RXDD_ZERO_WORD;
        end
        else if (apb_access)
        begin
            pready  <= 1'b1;
            pslverr <= !mapped;
            prdata  <= RXDD_ZERO_WORD;
            if (!pwrite)
            begin
                case (paddr)
                    RXDD_CTRL_OFS:   prdata <= {31'h0000_0000, run};
                    RXDD_BASE_OFS:   prdata <= list_base;
                    RXDD_STATUS_OFS: prdata <= status_word;
                    RXDD_CUR_OFS:    prdata <= cur_desc;
                    RXDD_CTLW_OFS:   prdata <= rx_desc_word1;
                    default:         prdata <= RXDD_ZERO_WORD;
                endcase
            end
        end
        else
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // Control and base registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            run       <= 1'b0;
            list_base <= RXDD_ZERO_WORD;
        end
        else if (apb_wr)
        begin
            if (paddr == RXDD_CTRL_OFS)
                run <= pwdata[RXDD_RUN_BIT];
            if (paddr == RXDD_BASE_OFS)
                list_base <= pwdata;
        end
    end

    // Resume request: a new write wins over the consume
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            poll_pend <= 1'b0;
        else if (apb_wr && paddr == RXDD_POLL_OFS)
            poll_pend <= 1'b1;
        else if (state == RXDD_SUSP)
            poll_pend <= 1'b0;
    end

    // Decoding of the control word
    // wrap overrides chain
    assign chained   = chain_pointer_flag && !ring_wrap_flag;
    assign buf2_used = !chained && (second_buf_len != RXDD_LEN_ZERO);

    // Following descriptor address
    always_comb
    begin
        if (ring_wrap_flag)
            next_desc = list_base;
        else if (chain_pointer_flag)
            next_desc = rx_desc_word3;
        else
            next_desc = cur_desc + RXDD_DESC_STRIDE;
    end

    // Entry offered to the FIFO
    always_comb
    begin
        push_valid = 1'b0;
        push_data  = '0;
        if (state == RXDD_PUSH1 && first_buf_len != RXDD_LEN_ZERO)
        begin
            push_valid = 1'b1;
            push_data  = {rx_desc_word2, first_buf_len, 1'b0};
        end
        else if (state == RXDD_PUSH2 && buf2_used)
        begin
            push_valid = 1'b1;
            push_data  = {rx_desc_word3, second_buf_len, 1'b1};
        end
    end

    // Memory read port: request held until acknowledged
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mem_rd_req  <= 1'b0;
            mem_rd_addr <= RXDD_ZERO_WORD;
        end
        else if (mem_rd_req)
        begin
            // Drop after the answer
            if (mem_rd_ack)
                mem_rd_req <= 1'b0;
        end
        else if (state == RXDD_FETCH && !mem_rd_ack)
        begin
            mem_rd_req  <= 1'b1;
            mem_rd_addr <= cur_desc + {28'h000_0000, word_idx, 2'b00};
        end
    end

    // Capture of fetched descriptor words
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ring_wrap_flag     <= 1'b0;
            chain_pointer_flag <= 1'b0;
            first_buf_len      <= RXDD_LEN_ZERO;
            second_buf_len     <= RXDD_LEN_ZERO;
            rx_desc_word1      <= RXDD_ZERO_WORD;
            rx_desc_word2      <= RXDD_ZERO_WORD;
            rx_desc_word3      <= RXDD_ZERO_WORD;
        end
        else if (state == RXDD_FETCH && mem_rd_req && mem_rd_ack)
        begin
            case (word_idx)
                2'h1:
                begin
                    rx_desc_word1      <= mem_rd_data;
                    ring_wrap_flag     <= mem_rd_data[RXDD_WRAP_BIT];
                    chain_pointer_flag <= mem_rd_data[RXDD_CHAIN_BIT];
                    first_buf_len  <= mem_rd_data[RXDD_LEN1_LO +: RXDD_LEN_W];
                    second_buf_len <= mem_rd_data[RXDD_LEN2_LO +: RXDD_LEN_W];
                end
                2'h2:
                    rx_desc_word2 <= mem_rd_data;
                2'h3:
                    rx_desc_word3 <= mem_rd_data;
                default:
                    ;
            endcase
        end
    end

    // Fetch engine
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state    <= RXDD_IDLE;
            cur_desc <= RXDD_ZERO_WORD;
            word_idx <= 2'h0;
        end
        else
        begin
            case (state)
                // Start at the list base
                RXDD_IDLE:
                begin
                    if (run)
                    begin
                        cur_desc <= list_base;
                        word_idx <= 2'h0;
                        state    <= RXDD_FETCH;
                    end
                end
                // Read the four words in order
                RXDD_FETCH:
                begin
                    if (mem_rd_req && mem_rd_ack)
                    begin
                        if (word_idx == 2'h0 && !mem_rd_data[RXDD_OWN_BIT])
                            state <= RXDD_SUSP;
                        else if (word_idx == RXDD_LAST_WORD)
                            state <= RXDD_PUSH1;
                        else
                            word_idx <= word_idx + 2'h1;
                    end
                end
                // First buffer entry, waits for room
                RXDD_PUSH1:
                begin
                    if (!push_valid || push_ready)
                        state <= RXDD_PUSH2;
                end
                // Second buffer entry, waits for room
                RXDD_PUSH2:
                begin
                    if (!push_valid || push_ready)
                        state <= RXDD_NEXT;
                end
                // Move to the following descriptor
                RXDD_NEXT:
                begin
                    cur_desc <= next_desc;
                    word_idx <= 2'h0;
                    state    <= run ? RXDD_FETCH : RXDD_IDLE;
                end
                // Suspended until a resume write, or back to idle once run is cleared
                RXDD_SUSP:
                begin
                    word_idx <= 2'h0;
                    if (!run)
                        state <= RXDD_IDLE;
                    else if (poll_pend)
                        state <= RXDD_FETCH;
                end
                default:
                    state <= RXDD_IDLE;
            endcase
        end
    end

    // Buffer entry queue
    rxdd_fifo #(
        .WIDTH (RXDD_ENTRY_W),
        .DEPTH (RXDD_FIFO_DEPTH)
    ) u_fifo (
        .clk       (pclk),
        .rst_n     (presetn),
        .in_valid  (push_valid),
        .in_ready  (push_ready),
        .in_data   (push_data),
        .out_valid (buf_valid),
        .out_ready (buf_ready),
        .out_data  (fifo_out)
    );

    // Entry fields on the consumer port
    assign buf_addr   = fifo_out[RXDD_ENTRY_W-1 -: RXDD_ADDR_W];
    assign buf_len    = fifo_out[RXDD_LEN_W:1];
    assign buf_second = fifo_out[0];

endmodule : rxdd_decoder

// >>> rxdd_decoder_sva.sv
// Checker for the receive descriptor decoder top ports.
// Assumes a single pclk domain with async active-low presetn.
module rxdd_decoder_sva (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        mem_rd_req,
    input wire logic [31:0] mem_rd_addr,
    input wire logic        mem_rd_ack,
    input wire logic [31:0] mem_rd_data,
    input wire logic        buf_valid,
    input wire logic        buf_ready,
    input wire logic [31:0] buf_addr,
    input wire logic [10:0] buf_len,
    input wire logic        buf_second
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Access phase answered on the next edge
    property p_apb_answer; psel && penable && !pready |=> pready; endproperty
    a_apb_answer: assert property (p_apb_answer) else $error("late pready");
    // Ready is a single pulse tied to an access
    property p_apb_pulse; pready |-> $past(psel && penable) ##1 !pready; endproperty
    a_apb_pulse: assert property (p_apb_pulse) else $error("stray pready");
    // Error flag only with ready
    property p_err_ready; pslverr |-> pready; endproperty
    a_err_ready: assert property (p_err_ready) else $error("pslverr alone");
    // Read request held until answered
    property p_req_hold;
        mem_rd_req && !mem_rd_ack |=> mem_rd_req && $stable(mem_rd_addr);
    endproperty
    a_req_hold: assert property (p_req_hold) else $error("request dropped");
    // Request drops after each answer
    property p_req_gap; mem_rd_req && mem_rd_ack |=> !mem_rd_req; endproperty
    a_req_gap: assert property (p_req_gap) else $error("no request gap");
    property p_word_step;
        mem_rd_req && mem_rd_ack && mem_rd_addr[3:2] != 2'h3
            && (mem_rd_addr[3:2] != 2'h0 || mem_rd_data[31])
        |-> ##2 mem_rd_req && mem_rd_addr == $past(mem_rd_addr, 2) + 32'h4;
    endproperty
    a_word_step: assert property (p_word_step) else $error("word order broken");
    property p_own_stop;
        mem_rd_req && mem_rd_ack && mem_rd_addr[3:2] == 2'h0 && !mem_rd_data[31]
        |=> !mem_rd_req [*8];
    endproperty
    a_own_stop: assert property (p_own_stop) else $error("fetch after unowned");
    // Entry held until taken
    property p_buf_hold;
        buf_valid && !buf_ready |=> buf_valid && $stable({buf_addr, buf_len, buf_second});
    endproperty
    a_buf_hold: assert property (p_buf_hold) else $error("entry changed");
    property p_len1_skip; buf_valid && !buf_second |-> buf_len != 11'h000; endproperty
    a_len1_skip: assert property (p_len1_skip) else $error("empty first buffer");
endmodule : rxdd_decoder_sva

// >>> rxdd_host_mem.sv
// Host memory model serving descriptor word reads.
// Assumes the bench fills mem by non-blocking writes; lat sets answer delay.
module rxdd_host_mem (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        mem_rd_req,
    input  wire logic [31:0] mem_rd_addr,
    input  wire logic [3:0]  lat,
    output logic             mem_rd_ack,
    output logic      [31:0] mem_rd_data
);
    logic [31:0] mem [256]; // Word store, index addr[9:2]
    logic [3:0]  cnt;       // Wait cycles so far

    // Wait counter per request
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            cnt <= 4'h0;
        else if (!mem_rd_req || mem_rd_ack)
            cnt <= 4'h0;
        else
            cnt <= cnt + 4'h1;

    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
        begin
            mem_rd_ack  <= 1'b0;
            mem_rd_data <= 32'h0000_0000;
        end
        else if (mem_rd_req && !mem_rd_ack && cnt == lat)
        begin
            mem_rd_ack  <= 1'b1;
            mem_rd_data <= mem[mem_rd_addr[9:2]];
        end
        else
        begin
            // Data line junk outside an answer
            mem_rd_ack  <= 1'b0;
            mem_rd_data <= ~mem_rd_data;
        end
endmodule : rxdd_host_mem

// >>> rxdd_decoder_tb.sv
// Self-checking bench for the receive descriptor decoder.
// Assumes rxdd_pkg, rxdd_decoder, rxdd_host_mem and the checker compiled.
module rxdd_decoder_tb;
    import rxdd_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, mem_rd_addr, mem_rd_data, buf_addr;
    logic        pready, pslverr, mem_rd_req, mem_rd_ack, buf_valid, buf_second;
    logic        buf_ready = 0;
    logic [10:0] buf_len;
    logic [3:0]  lat = 4'h0;
    int          n_errors = 0, compares = 0, cyc = 0;

    always #5 pclk = ~pclk;
    rxdd_decoder rxdd_decoder_inst (.pclk(pclk), .presetn(presetn), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .mem_rd_req(mem_rd_req),
        .mem_rd_addr(mem_rd_addr), .mem_rd_ack(mem_rd_ack), .mem_rd_data(mem_rd_data),
        .buf_valid(buf_valid), .buf_ready(buf_ready), .buf_addr(buf_addr),
        .buf_len(buf_len), .buf_second(buf_second));
    rxdd_host_mem rxdd_host_mem_inst (.pclk(pclk), .presetn(presetn),
        .mem_rd_req(mem_rd_req), .mem_rd_addr(mem_rd_addr), .lat(lat),
        .mem_rd_ack(mem_rd_ack), .mem_rd_data(mem_rd_data));

    // Closing report
    task automatic wrap_up;
        $display("compares=%0d n_errors=%0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : wrap_up

    // Hang guard
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_errors++;
            wrap_up();
        end
    end

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e)
        begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk

    // APB transfer, held until pready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        @(posedge pclk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 0; penable <= 0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1, a, d, r, e);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
        logic [31:0] r;
        logic        e;
        apb(0, a, 32'h0, r, e);
        chk(r, x);
        chk({31'h0, e}, {31'h0, xe});
    endtask : rd

    // Wait for one entry, consumer held ready
    task automatic pop(output bit got);
        got = 0;
        repeat (30)
        begin
            @(posedge pclk);
            if (buf_valid === 1'b1)
            begin
                got = 1;
                break;
            end
        end
    endtask : pop

    task automatic ent(input logic [31:0] a, input logic [10:0] l, input logic s);
        chk(buf_addr, a);
        chk({21'h0, buf_len}, {21'h0, l});
        chk({31'h0, buf_second}, {31'h0, s});
    endtask : ent

    task automatic put(input int i, input logic [31:0] w0, w1, w2, w3);
        rxdd_host_mem_inst.mem[i] <= w0;
        rxdd_host_mem_inst.mem[i+1] <= w1;
        rxdd_host_mem_inst.mem[i+2] <= w2;
        rxdd_host_mem_inst.mem[i+3] <= w3;
    endtask : put

    // Reset values and unmapped access
    task automatic t_regs;
        rd(RXDD_CTRL_OFS, RXDD_ZERO_WORD, 0);
        wr(8'h20, 32'hFFFF_FFFF);
        rd(8'h20, 32'h0, 1);
        wr(RXDD_BASE_OFS, 32'h100);
        rd(RXDD_BASE_OFS, 32'h100, 0);
        $display("t_regs done");
    endtask : t_regs

    // Plain, chained and wrapping walk to a suspend
    task automatic t_walk;
        bit got;
        put(64, 32'h8000_0000, 32'hFCC1_0040, 32'h1001, 32'h2000);
        put(68, 32'h8000_0000, 32'h0100_0008, 32'h5002, 32'h140);
        put(80, 32'h8000_0000, 32'h0000_8000, 32'h9999, 32'h3000);
        // wrap beats chain, lengths passed unscaled
        put(84, 32'h8000_0000, 32'h0300_000C, 32'h6003, 32'h180);
        lat <= 4'h2;
        wr(RXDD_CTRL_OFS, 32'h1);
        do @(posedge pclk); while (!(mem_rd_req && mem_rd_addr == 32'h15C));
        rxdd_host_mem_inst.mem[64] <= 32'h0;
        repeat (60) @(posedge pclk);
        rd(RXDD_STATUS_OFS, 32'h15, 0);
        rd(RXDD_CUR_OFS, 32'h100, 0);
        rd(RXDD_CTLW_OFS, 32'h0300_000C, 0);
        // Resume write refetches, still not owned
        wr(RXDD_POLL_OFS, 32'h1);
        do @(posedge pclk); while (!(mem_rd_req && mem_rd_addr == 32'h100));
        repeat (20) @(posedge pclk);
        rd(RXDD_STATUS_OFS, 32'h15, 0);
        rd(RXDD_CUR_OFS, 32'h100, 0);
        buf_ready <= 1;
        pop(got);
        ent(32'h1001, 11'h40, 0);
        pop(got);
        ent(32'h2000, 11'h20, 1);
        pop(got);
        ent(32'h5002, 11'h8, 0);
        pop(got);
        ent(32'h3000, 11'h10, 1);
        pop(got);
        ent(32'h6003, 11'hC, 0);
        pop(got);
        chk({31'h0, got}, 32'h0);
        buf_ready <= 0;
        wr(RXDD_CTRL_OFS, 32'h0);
        rd(RXDD_STATUS_OFS, 32'h0, 0);
        $display("t_walk done");
    endtask : t_walk

    // Queue filled to a stall, then drained
    task automatic t_fill;
        bit got;
        int n;
        put(128, 32'h8000_0000, 32'h0200_6004, 32'h7000, 32'h7100);
        wr(RXDD_BASE_OFS, 32'h200);
        wr(RXDD_CTRL_OFS, 32'h1);
        repeat (400) @(posedge pclk);
        chk({31'h0, buf_valid}, 32'h1);
        chk({31'h0, mem_rd_req}, 32'h0);
        wr(RXDD_CTRL_OFS, 32'h0);
        buf_ready <= 1;
        n = 0;
        do
        begin
            pop(got);
            if (got)
            begin
                if (n % 2 == 0) ent(32'h7000, 11'h4, 0);
                else ent(32'h7100, 11'hC, 1);
                n++;
            end
        end
        while (got);
        chk({31'h0, n >= 17}, 32'h1);
        rd(RXDD_STATUS_OFS, 32'h0, 0);
        $display("t_fill done");
    endtask : t_fill

    initial
    begin
        repeat (3) @(posedge pclk);
        presetn <= 1;
        t_regs();
        t_walk();
        t_fill();
        wrap_up();
    end
endmodule : rxdd_decoder_tb

bind rxdd_decoder rxdd_decoder_sva rxdd_decoder_sva_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
    .mem_rd_req(mem_rd_req), .mem_rd_addr(mem_rd_addr), .mem_rd_ack(mem_rd_ack),
    .mem_rd_data(mem_rd_data), .buf_valid(buf_valid), .buf_ready(buf_ready),
    .buf_addr(buf_addr), .buf_len(buf_len), .buf_second(buf_second));
